/* File: verilog/dmm_pkg.sv */
`default_nettype none
package dmm_pkg;

   // Data space
   localparam int          ADDR_W         = 12;
   localparam int          MEM_DEPTH      = 4096;
   localparam logic [11:0] ADDR_MAX       = 12'hfff;

   // Special registers seen through the data space
   localparam logic [11:0] ACC_ADDR       = 12'hfe8;
   localparam logic [11:0] BANK_ADDR      = 12'hfe0;
   localparam logic [11:0] PROD_HI_ADDR   = 12'hff4;
   localparam logic [11:0] PROD_LO_ADDR   = 12'hff3;

   // Access bank: low part from 000h, high part from f80h
   localparam logic [7:0]  ACCESS_SPLIT   = 8'h80;
   localparam logic [3:0]  ACCESS_HI_PAGE = 4'hf;
   localparam logic [3:0]  ACCESS_LO_PAGE = 4'h0;

   // Opcode fields
   localparam logic [3:0]  OP_MOVE_SRC    = 4'hc;
   localparam logic [3:0]  OP_MOVE_DST    = 4'hf;
   localparam logic [7:0]  OP_BANK_LIT    = 8'h01;
   localparam logic [7:0]  OP_ACC_LIT     = 8'h0e;
   localparam logic [7:0]  OP_MUL_LIT     = 8'h0d;
   localparam logic [6:0]  OP_STORE_ACC   = 7'h37;

   // Register map, byte addresses
   localparam logic [7:0]  REG_INSTR      = 8'h00;
   localparam logic [7:0]  REG_STATUS     = 8'h04;
   localparam logic [7:0]  REG_ACC        = 8'h08;
   localparam logic [7:0]  REG_BANK       = 8'h0c;
   localparam logic [7:0]  REG_PROD       = 8'h10;
   localparam logic [7:0]  REG_MEM_ADDR   = 8'h14;
   localparam logic [7:0]  REG_MEM_DATA   = 8'h18;

   // Status bit positions
   localparam int          ST_BUSY_BIT    = 0;
   localparam int          ST_WAIT_BIT    = 1;
   localparam int          ST_BADSEQ_BIT  = 2;
   localparam int          ST_BADOP_BIT   = 3;

   // Values after reset
   localparam logic [7:0]  ACC_RST        = 8'h00;
   localparam logic [7:0]  BANK_RST       = 8'h00;
   localparam logic [7:0]  PROD_RST       = 8'h00;
   localparam logic [15:0] INSTR_RST      = 16'h0000;

   // Phases of one instruction cycle
   typedef enum logic [1:0] {
      Q1 = 2'b00,
      Q2 = 2'b01,
      Q3 = 2'b10,
      Q4 = 2'b11
   } dmm_phase_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_EXEC  = 2'b01,
      ST_WAIT2 = 2'b10,
      ST_EXEC2 = 2'b11
   } dmm_state_t;

   typedef enum logic [2:0] {
      OPC_NOP   = 3'b000,
      OPC_MOVE  = 3'b001,
      OPC_BANK  = 3'b010,
      OPC_ACC   = 3'b011,
      OPC_STORE = 3'b100,
      OPC_MUL   = 3'b101,
      OPC_BAD   = 3'b110
   } dmm_opc_t;

   // One write into the data space
   typedef struct packed {
      logic        en;
      logic [11:0] addr;
      logic [7:0]  data;
   } dmm_wr_t;

endpackage : dmm_pkg
`default_nettype wire

/* File: verilog/dmm_phase_gen.sv */
`default_nettype none
module dmm_phase_gen (
   // Clock and reset
   input  wire logic           pclk,
   input  wire logic           presetn,
   // Control
   input  wire logic           run,
   // Phase outputs
   output dmm_pkg::dmm_phase_t phase,
   output logic                cycle_last
);
   import dmm_pkg::*;

   // Phase steps once per clock while running, restarts at Q1 when stopped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase <= Q1;
      end else if (!run) begin
         phase <= Q1;
      end else begin
         phase <= dmm_phase_t'(phase + 2'b01);
      end
   end

   // Marks the final phase so the sequencer can leave on time
   assign cycle_last = run && (phase == Q4);

endmodule // dmm_phase_gen
`default_nettype wire

/* File: verilog/dmm_data_mem.sv */
`default_nettype none
module dmm_data_mem (
   // Clock
   input  wire logic            pclk,
   // Write port
   input  wire dmm_pkg::dmm_wr_t wr,
   // Read port
   input  wire logic [11:0]     rd_addr,
   output logic [7:0]           rd_data
);
   import dmm_pkg::*;

   logic [7:0] mem [MEM_DEPTH];

   // Plain storage, no reset: contents are undefined until written
   always_ff @(posedge pclk) begin
      if (wr.en) begin
         mem[wr.addr] <= wr.data;
      end
   end

   // Read is combinational so a phase can sample it in the same cycle
   assign rd_data = mem[rd_addr];

endmodule // dmm_data_mem
`default_nettype wire

/* File: verilog/dmm_core.sv */
`default_nettype none
module dmm_core (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr
);
   import dmm_pkg::*;

   dmm_state_t  state;
   dmm_state_t  next_state;
   dmm_phase_t  phase;
   logic        cycle_last;
   dmm_opc_t    opc;
   logic [15:0] instr;
   logic [7:0]  move_data;
   logic [7:0]  acc;
   logic [7:0]  bank_sel;
   logic [7:0]  prod_hi;
   logic [7:0]  prod_lo;
   logic [11:0] mem_addr;
   logic        bad_seq;
   logic        bad_op;
   logic [11:0] rd_addr;
   logic [7:0]  mem_rd;
   logic [7:0]  space_rd;
   dmm_wr_t     space_wr;
   dmm_wr_t     mem_wr;
   logic [15:0] mul_res;
   logic        busy;
   logic        mapped;
   logic        can_go;
   logic        fresh;
   logic        xfer;
   logic        wr_xfer;
   logic        issue;
   logic        second_ok;
   logic [31:0] next_prdata;

   // Decode one program word into an operation class
   function automatic dmm_opc_t decode(input logic [15:0] w);
      dmm_opc_t r;
      r = OPC_BAD;
      if (w[15:12] == OP_MOVE_SRC) begin
         r = OPC_MOVE;
      end else if (w[15:12] == OP_MOVE_DST) begin
         r = OPC_NOP;
      end else if (w[15:8] == OP_BANK_LIT) begin
         r = OPC_BANK;
      end else if (w[15:8] == OP_ACC_LIT) begin
         r = OPC_ACC;
      end else if (w[15:8] == OP_MUL_LIT) begin
         r = OPC_MUL;
      end else if (w[15:9] == OP_STORE_ACC) begin
         r = OPC_STORE;
      end
      return r;
   endfunction

   // Form a 12-bit address from an 8-bit file field, the access bit and the bank register
   function automatic logic [11:0] file_addr(input logic       a,
                                             input logic [7:0] f,
                                             input logic [7:0] bank);
      logic [11:0] r;
      r = {bank[3:0], f};
      if (!a) begin
         r = (f < ACCESS_SPLIT) ? {ACCESS_LO_PAGE, f}
                                : {ACCESS_HI_PAGE, f};
      end
      return r;
   endfunction

   // True where the data space holds a core register, not memory
   function automatic logic is_core_reg(input logic [11:0] a);
      return (a == ACC_ADDR) || (a == BANK_ADDR) ||
             (a == PROD_HI_ADDR) || (a == PROD_LO_ADDR);
   endfunction

   assign opc     = decode(instr);
   assign busy    = (state == ST_EXEC) || (state == ST_EXEC2);
   assign mul_res = {8'h00, acc} * {8'h00, instr[7:0]};

   dmm_phase_gen u_phase (
      .pclk       (pclk),
      .presetn    (presetn),
      .run        (busy),
      .phase      (phase),
      .cycle_last (cycle_last)
   );

   dmm_data_mem u_mem (
      .pclk    (pclk),
      .wr      (mem_wr),
      .rd_addr (rd_addr),
      .rd_data (mem_rd)
   );

   // APB decode; instruction and memory data ports wait while a cycle runs
   always_comb begin
      mapped = (paddr == REG_INSTR) || (paddr == REG_STATUS) ||
               (paddr == REG_ACC) || (paddr == REG_BANK) ||
               (paddr == REG_PROD) || (paddr == REG_MEM_ADDR) ||
               (paddr == REG_MEM_DATA);
      can_go = !busy || !((paddr == REG_INSTR) ||
                          (paddr == REG_MEM_DATA));
   end

   // Read data is registered, so an answer needs one settled cycle first
   assign pready  = psel && penable && can_go && fresh;
   assign pslverr = pready && !mapped;
   assign xfer    = pready && mapped;
   assign wr_xfer = xfer && pwrite;
   assign issue   = wr_xfer && (paddr == REG_INSTR);
   assign second_ok = (pwdata[15:12] == OP_MOVE_DST);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fresh <= 1'b0;
      end else begin
         fresh <= psel && can_go && !pready;
      end
   end

   // Data space read: the source of a move, else the software pointer
   always_comb begin
      rd_addr = mem_addr;
      if (state == ST_EXEC) begin
         rd_addr = instr[11:0];
      end
      case (rd_addr)
         ACC_ADDR:     space_rd = acc;
         BANK_ADDR:    space_rd = bank_sel;
         PROD_HI_ADDR: space_rd = prod_hi;
         PROD_LO_ADDR: space_rd = prod_lo;
         default:      space_rd = mem_rd;
      endcase
   end

   // One data space write per cycle; core writes happen only in Q4
   always_comb begin
      space_wr = '0;
      if ((state == ST_EXEC) && (phase == Q4) && (opc == OPC_STORE)) begin
         space_wr.en   = 1'b1;
         space_wr.addr = file_addr(instr[8], instr[7:0], bank_sel);
         space_wr.data = acc;
      end else if ((state == ST_EXEC2) && (phase == Q4)) begin
         space_wr.en   = 1'b1;
         space_wr.addr = instr[11:0];
         space_wr.data = move_data;
      end else if (wr_xfer && (paddr == REG_MEM_DATA)) begin
         space_wr.en   = 1'b1;
         space_wr.addr = mem_addr;
         space_wr.data = pwdata[7:0];
      end
      mem_wr    = space_wr;
      mem_wr.en = space_wr.en && !is_core_reg(space_wr.addr);
   end

   // Sequencer; a move waits in ST_WAIT2 for its second word
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (issue) begin
               next_state = ST_EXEC;
            end
         end
         ST_EXEC: begin
            if (cycle_last) begin
               next_state = (opc == OPC_MOVE) ? ST_WAIT2 : ST_IDLE;
            end
         end
         ST_WAIT2: begin
            if (issue) begin
               next_state = second_ok ? ST_EXEC2 : ST_IDLE;
            end
         end
         ST_EXEC2: begin
            if (cycle_last) begin
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Instruction word; a bad second word leaves the first one in place
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         instr <= INSTR_RST;
      end else if (issue && ((state == ST_IDLE) || second_ok)) begin
         instr <= pwdata[15:0];
      end
   end

   // Source byte caught in Q2 of the first move cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         move_data <= 8'h00;
      end else if ((state == ST_EXEC) && (phase == Q2) &&
                   (opc == OPC_MOVE)) begin
         move_data <= space_rd;
      end
   end

   // Accumulator; loads touch no flags, the block keeps only the two sticky error flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc <= ACC_RST;
      end else if (space_wr.en && (space_wr.addr == ACC_ADDR)) begin
         acc <= space_wr.data;
      end else if ((state == ST_EXEC) && (phase == Q4) &&
                   (opc == OPC_ACC)) begin
         acc <= instr[7:0];
      end else if (wr_xfer && (paddr == REG_ACC)) begin
         acc <= pwdata[7:0];
      end
   end

   // Bank register, full 8 bits kept, low nibble used for addressing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bank_sel <= BANK_RST;
      end else if (space_wr.en && (space_wr.addr == BANK_ADDR)) begin
         bank_sel <= space_wr.data;
      end else if ((state == ST_EXEC) && (phase == Q4) &&
                   (opc == OPC_BANK)) begin
         bank_sel <= instr[7:0];
      end
   end

   // Product pair, high byte in the upper register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prod_hi <= PROD_RST;
         prod_lo <= PROD_RST;
      end else if ((state == ST_EXEC) && (phase == Q4) &&
                   (opc == OPC_MUL)) begin
         prod_hi <= mul_res[15:8];
         prod_lo <= mul_res[7:0];
      end else if (space_wr.en) begin
         if (space_wr.addr == PROD_HI_ADDR) begin
            prod_hi <= space_wr.data;
         end
         if (space_wr.addr == PROD_LO_ADDR) begin
            prod_lo <= space_wr.data;
         end
      end
   end

   // Software pointer into the data space
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_addr <= 12'h000;
      end else if (wr_xfer && (paddr == REG_MEM_ADDR)) begin
         mem_addr <= pwdata[11:0] & ADDR_MAX;
      end
   end

   // Sticky error flags; a new event beats a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bad_seq <= 1'b0;
         bad_op  <= 1'b0;
      end else begin
         if ((state == ST_WAIT2) && issue && !second_ok) begin
            bad_seq <= 1'b1;
         end else if (wr_xfer && (paddr == REG_STATUS) &&
                      pwdata[ST_BADSEQ_BIT]) begin
            bad_seq <= 1'b0;
         end
         if ((state == ST_EXEC) && (phase == Q1) && (opc == OPC_BAD)) begin
            bad_op <= 1'b1;
         end else if (wr_xfer && (paddr == REG_STATUS) &&
                      pwdata[ST_BADOP_BIT]) begin
            bad_op <= 1'b0;
         end
      end
   end

   // Read mux, sampled every selected cycle ahead of the answer
   always_comb begin
      next_prdata = 32'h0000_0000;
      case (paddr)
         REG_INSTR:    next_prdata = {16'h0000, instr};
         REG_STATUS: begin
            next_prdata[ST_BUSY_BIT]   = busy;
            next_prdata[ST_WAIT_BIT]   = (state == ST_WAIT2);
            next_prdata[ST_BADSEQ_BIT] = bad_seq;
            next_prdata[ST_BADOP_BIT]  = bad_op;
         end
         REG_ACC:      next_prdata = {24'h000000, acc};
         REG_BANK:     next_prdata = {24'h000000, bank_sel};
         REG_PROD:     next_prdata = {16'h0000, prod_hi, prod_lo};
         REG_MEM_ADDR: next_prdata = {20'h00000, mem_addr};
         REG_MEM_DATA: next_prdata = {24'h000000, space_rd};
         default:      next_prdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !pready) begin
         prdata <= next_prdata;
      end
   end
endmodule // dmm_core
`default_nettype wire

/* File: bench/dmm_core_properties.sv */
`default_nettype none
module dmm_core_properties (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   import dmm_pkg::*;
   logic [3:0] last_nib;
   logic       acc_ph;
   logic       take;
   logic       runs;
   logic       fast;
   // Access phase and accepted program word
   assign acc_ph = psel && penable;
   assign take   = acc_ph && pready && pwrite && paddr == REG_INSTR;
   assign fast   = paddr inside {REG_STATUS, REG_ACC, REG_BANK, REG_PROD,
                                 REG_MEM_ADDR};
   // Discarded words start no cycle and lone tails run an empty cycle, yet both are left out
   assign runs = (last_nib == OP_MOVE_SRC) ? pwdata[15:12] == OP_MOVE_DST
                                           : pwdata[15:12] != OP_MOVE_DST;
   // Top nibble of the last word taken tells whether a move waits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_nib <= 4'h0;
      end else if (take) begin
         last_nib <= pwdata[15:12];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_err_ready;
      pslverr |-> pready && acc_ph;
   endproperty
   a_err_ready: assert property (p_err_ready) else $error("stray error");
   property p_unmapped;
      acc_ph && pready && (paddr > REG_MEM_DATA || paddr[1:0] != 2'b00)
         |-> pslverr;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("no error");
   property p_mapped;
      acc_ph && paddr <= REG_MEM_DATA && paddr[1:0] == 2'b00 |-> !pslverr;
   endproperty
   a_mapped: assert property (p_mapped) else $error("mapped error");
   property p_fast;
      acc_ph && fast |-> pready;
   endproperty
   a_fast: assert property (p_fast) else $error("register stalled");
   property p_instr_stall;
      take && runs |=> !(acc_ph && pready && paddr == REG_INSTR) [*4];
   endproperty
   a_instr_stall: assert property (p_instr_stall)
      else $error("early");
   property p_bank_width;
      acc_ph && pready && !pwrite && paddr == REG_BANK
         |-> prdata[31:8] == 24'h0;
   endproperty
   a_bank_width: assert property (p_bank_width) else $error("bank");
   property p_prod_width;
      acc_ph && pready && !pwrite && paddr == REG_PROD
         |-> prdata[31:16] == 16'h0;
   endproperty
   a_prod_width: assert property (p_prod_width) else $error("prod");
   property p_hold;
      !psel && !$past(psel) |-> $stable(prdata);
   endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
endmodule // dmm_core_properties

bind dmm_core dmm_core_properties dmm_core_properties_inst (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr));
`default_nettype wire

/* File: bench/dmm_prog_mem.sv */
`default_nettype none
module dmm_prog_mem (
   // Fetch
   input  wire logic [3:0]  pc,
   output logic      [15:0] word
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] rom [16];
   // Program: no move targets counter or stack bytes, nor interrupt setup
   initial begin
      rom = '{16'h0e5a, 16'h0105, 16'h0ee2, 16'h0dc4, 16'h0eff, 16'h0dff,
              16'h6e90, 16'h6f20, 16'hc000, 16'hffff, 16'hc000, 16'hffe8,
              16'hcfe8, 16'hf123, 16'hc000, 16'h0e77};
   end
   assign word = rom[pc];
endmodule // dmm_prog_mem
`default_nettype wire

/* File: bench/tb_dmm_core.sv */
`default_nettype none
module tb_dmm_core;
   timeunit 1ns;
   timeprecision 1ps;
   import dmm_pkg::*;
   logic        pclk    = 1'b0;
   logic        presetn = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0;
   logic [3:0]  pc      = 4'h0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic        pready;
   logic        pslverr;
   logic        err;
   logic [15:0] word;
   int          fails           = 0;
   int          samples_checked = 0;
   dmm_core dmm_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   dmm_prog_mem dmm_prog_mem_inst (.pc(pc), .word(word));
   // 100 MHz clock
   always #5 pclk = ~pclk;
   // One APB transfer; holds the request until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task automatic memwr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, REG_MEM_ADDR, {20'h0, a});
      apb(1'b1, REG_MEM_DATA, {24'h0, d});
   endtask
   task automatic memchk(input logic [11:0] a, input logic [7:0] exp);
      apb(1'b1, REG_MEM_ADDR, {20'h0, a});
      rdchk(REG_MEM_DATA, {24'h0, exp});
   endtask
   // Issue the next program word; the result lands four cycles later
   task automatic issue(input int settle);
      // Let the program counter bumped by the last issue settle first
      @(negedge pclk);
      apb(1'b1, REG_INSTR, {16'h0, word});
      pc <= pc + 4'h1;
      repeat (settle) @(posedge pclk);
   endtask
   task automatic run(input int cnt);
      repeat (cnt) issue(4);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Watchdog: the run needs well under a thousand cycles
   initial begin
      #50us;
      fails++;
      finish_test();
   end
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(REG_ACC, 32'h0);
      rdchk(REG_PROD, 32'h0);
      rdchk(REG_BANK, 32'h0);
      $display("reset test done");
      // Second word is sent while the first still runs and stalls until it ends
      issue(0);
      run(1);
      rdchk(REG_ACC, 32'h5a);
      rdchk(REG_BANK, 32'h05);
      rdchk(REG_STATUS, 32'h0);
      $display("literal test done");
      run(2);
      rdchk(REG_PROD, 32'had08);
      rdchk(REG_ACC, 32'he2);
      run(2);
      rdchk(REG_PROD, 32'hfe01);
      rdchk(REG_ACC, 32'hff);
      $display("multiply test done");
      run(2);
      memchk(12'hf90, 8'hff);
      memchk(12'h520, 8'hff);
      rdchk(REG_ACC, 32'hff);
      $display("store test done");
      memwr(12'h000, 8'h33);
      issue(0);
      apb(1'b0, REG_STATUS, 32'h0);
      chk({31'h0, rd[ST_BUSY_BIT]}, 32'h1);
      rdchk(REG_STATUS, 32'h2);
      run(1);
      memchk(12'hfff, 8'h33);
      memchk(12'h000, 8'h33);
      run(2);
      rdchk(REG_ACC, 32'h33);
      apb(1'b1, REG_ACC, 32'h4c);
      run(2);
      memchk(12'h123, 8'h4c);
      $display("move test done");
      // A pair broken by a foreign second word is dropped
      run(2);
      rdchk(REG_STATUS, 32'h4);
      rdchk(REG_ACC, 32'h4c);
      apb(1'b1, REG_STATUS, 32'h4);
      rdchk(REG_STATUS, 32'h0);
      apb(1'b0, 8'h1c, 32'h0);
      chk({31'h0, err}, 32'h1);
      // An unsupported opcode runs as an empty cycle and flags itself
      apb(1'b1, REG_INSTR, 32'h0000_0000);
      repeat (4) @(posedge pclk);
      rdchk(REG_STATUS, 32'h8);
      apb(1'b1, REG_STATUS, 32'h8);
      rdchk(REG_STATUS, 32'h0);
      $display("error test done");
      finish_test();
   end
endmodule // tb_dmm_core
`default_nettype wire
